// ===== src/rsf_consts.svh
/*
  Constants for the return and software-reset flow block: instruction
  encodings, instruction field positions, register offsets, reset values.
  Assumes it is included by bare name by every file that needs it.
*/
`ifndef RSF_CONSTS_SVH
`define RSF_CONSTS_SVH

////////////////////////////////////////////////////////////////////////
// instruction encodings (24-bit words)
`define RSF_OP_SOFT_RESET 24'hFE0000
`define RSF_OP_RET_INT 24'h064000
`define RSF_OP_RET_SUB 24'h060000
// return_with_literal: bits 23:15 fixed, then byte select, k, d
`define RSF_LITRET_MSB 23
`define RSF_LITRET_LSB 15
`define RSF_LITRET_CODE 9'h00A
`define RSF_BYTE_SEL_BIT 14
`define RSF_LIT_MSB 13
`define RSF_LIT_LSB 4
`define RSF_DST_MSB 3
`define RSF_DST_LSB 0

////////////////////////////////////////////////////////////////////////
// popped status word layout
`define RSF_TOP_PCHI_MSB 6
`define RSF_TOP_PCHI_LSB 0
`define RSF_TOP_PRIO3_BIT 7
`define RSF_TOP_SR_MSB 15
`define RSF_TOP_SR_LSB 8
`define RSF_PRIO3_BIT 3
`define RSF_SR_PRIO_MSB 7
`define RSF_SR_PRIO_LSB 5
`define RSF_SOFT_RESET_FLAG_BIT 6
`define RSF_POP_STEP 16'h0002

////////////////////////////////////////////////////////////////////////
// register offsets on the plain register port
`define RSF_ADDR_PC_LO 8'h00
`define RSF_ADDR_PC_HI 8'h04
`define RSF_ADDR_SP 8'h08
`define RSF_ADDR_SR 8'h0C
`define RSF_ADDR_CORE_CTRL 8'h10
`define RSF_ADDR_RESET_CTRL 8'h14

////////////////////////////////////////////////////////////////////////
// power-on values
`define RSF_RST_PC_LO 16'h0000
`define RSF_RST_PC_HI 7'h00
`define RSF_RST_SP 16'h0000
`define RSF_RST_SR 16'h0000
`define RSF_RST_CORE_CTRL 16'h0020
`define RSF_RST_RESET_CTRL 16'h0000

`endif

// ===== src/rsf_pkg.sv
/*
  Types of the return and software-reset flow block.
  Assumes nothing beyond the constants header.
*/
package rsf_pkg;

  // flow sequencer states
  typedef enum logic [1:0] {
    RSF_IDLE = 2'b00,
    RSF_POP_LO = 2'b01,
    RSF_FLUSH = 2'b10
  } rsf_state_type;

  // instruction being executed
  typedef enum logic [1:0] {
    RSF_NONE = 2'b00,
    RSF_RET_INT = 2'b01,
    RSF_RET_SUB = 2'b10,
    RSF_RET_LIT = 2'b11
  } rsf_op_type;

  // decoded return_with_literal fields
  typedef struct packed {
    logic byte_mode;
    logic [9:0] lit;
    logic [3:0] dst;
  } rsf_lit_fields_type;

  // write into the working register file
  typedef struct packed {
    logic en;
    logic [3:0] idx;
    logic [15:0] data;
  } rsf_wreg_wr_type;

endpackage

// ===== src/rsf_stack_pop.sv
/*
  Stack pop address unit: address of the top word and the lowered pointer.
  Assumes a word-aligned stack pointer that grows upward.
*/
`timescale 1ns/1ps
`include "rsf_consts.svh"

module rsf_stack_pop (
  input wire logic [15:0] sp,
  output logic [15:0] pop_addr
);

  // top word sits one word below the pointer; bit 0 forced to word alignment
  always_comb begin
    pop_addr = (sp - `RSF_POP_STEP) & 16'hFFFE;
  end

endmodule

// ===== src/rsf_lit_merge.sv
/*
  Literal field decoder and byte/word merge for return_with_literal.
  Assumes wreg_old is the current value of the selected working register.
*/
`timescale 1ns/1ps
`include "rsf_consts.svh"

module rsf_lit_merge (
  input wire logic [23:0] instr_word,
  input wire logic [15:0] wreg_old,
  output rsf_pkg::rsf_lit_fields_type fields,
  output logic [15:0] merged
);

  // field extraction and merge into the destination value
  always_comb begin
    fields.byte_mode = instr_word[`RSF_BYTE_SEL_BIT];
    fields.lit = instr_word[`RSF_LIT_MSB:`RSF_LIT_LSB];
    fields.dst = instr_word[`RSF_DST_MSB:`RSF_DST_LSB];
    if (fields.byte_mode) begin
      // byte mode: literal limited to 0..255, upper byte kept
      merged = {wreg_old[15:8], fields.lit[7:0]};
    end else begin
      // word mode: literal 0..1023 zero-extended
      merged = {6'h00, fields.lit};
    end
  end

endmodule

// ===== src/rsf_flow.sv
/*
  Return and software-reset flow: executes software reset, return from
  interrupt, return with literal and subroutine return, popping the
  software stack and holding PC, stack pointer, status, core control and
  reset control registers behind a plain register port.
  Assumes a stack memory with same-cycle read data, a working register
  file with a combinational read port, and instructions offered one at a
  time while instr_ready is high.
*/
// Local design decisions: the register addresses and the plain strobed port.
// What this block does
// - software reset sets the software_reset_flag, reset control bit 6
// - return_from_interrupt pop restores low status byte and priority bit 3
// - same pop restores PC 22:16, second pop gives PC 15:0, two per pop
// - return_from_interrupt restores the priority level from before service
// - return_with_literal literal is 0..255 in byte mode, 0..1023 word mode
// - byte/word select bit: 0 means word, 1 means byte
// - literal from 10-bit k field, destination register from 4-bit d field
`timescale 1ns/1ps
`include "rsf_consts.svh"

module rsf_flow (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic instr_valid,
  input wire logic [23:0] instr_word,
  input wire logic exception_pending,
  output logic instr_ready,
  output logic flow_done,
  output logic soft_reset_pulse,
  output logic [15:0] stack_addr,
  output logic stack_rd,
  input wire logic [15:0] stack_rdata,
  output logic [3:0] wreg_sel,
  input wire logic [15:0] wreg_old,
  output rsf_pkg::rsf_wreg_wr_type wreg_wr,
  output logic [22:0] pc,
  output logic [3:0] interrupt_priority_level,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata
);

  ////////////////////////////////////////////////////////////////////////
  // state
  rsf_pkg::rsf_state_type state;
  rsf_pkg::rsf_state_type next_state;
  rsf_pkg::rsf_op_type op;
  rsf_pkg::rsf_op_type next_op;
  logic [15:0] pc_lo;
  logic [15:0] next_pc_lo;
  logic [6:0] pc_hi;
  logic [6:0] next_pc_hi;
  logic [15:0] sp;
  logic [15:0] next_sp;
  logic [15:0] sr;
  logic [15:0] next_sr;
  logic [15:0] core_ctrl;
  logic [15:0] next_core_ctrl;
  logic [15:0] reset_ctrl;
  logic [15:0] next_reset_ctrl;
  logic [15:0] lit_hold;
  logic [15:0] next_lit_hold;
  logic [3:0] dst_hold;
  logic [3:0] next_dst_hold;
  rsf_pkg::rsf_wreg_wr_type next_wreg_wr;
  logic next_soft_reset_pulse;
  logic [15:0] next_reg_rdata;

  // decode helpers
  rsf_pkg::rsf_lit_fields_type lit_fields;
  logic [15:0] lit_merged;
  logic take;
  logic is_soft_reset;
  logic is_ret_int;
  logic is_ret_sub;
  logic is_ret_lit;

  ////////////////////////////////////////////////////////////////////////
  // helpers
  rsf_stack_pop u_pop (
    .sp(sp),
    .pop_addr(stack_addr)
  );

  rsf_lit_merge u_lit (
    .instr_word(instr_word),
    .wreg_old(wreg_old),
    .fields(lit_fields),
    .merged(lit_merged)
  );

  ////////////////////////////////////////////////////////////////////////
  // instruction decode
  always_comb begin
    take = instr_valid && (state == rsf_pkg::RSF_IDLE);
    is_soft_reset = (instr_word == `RSF_OP_SOFT_RESET);
    is_ret_int = (instr_word == `RSF_OP_RET_INT);
    is_ret_sub = (instr_word == `RSF_OP_RET_SUB);
    is_ret_lit = (instr_word[`RSF_LITRET_MSB:`RSF_LITRET_LSB] == `RSF_LITRET_CODE);
  end

  // handshakes and visible state
  always_comb begin
    instr_ready = (state == rsf_pkg::RSF_IDLE);
    flow_done = (state == rsf_pkg::RSF_FLUSH) ||
                ((state == rsf_pkg::RSF_POP_LO) && exception_pending);
    wreg_sel = lit_fields.dst;
    pc = {pc_hi, pc_lo};
    interrupt_priority_level = {core_ctrl[`RSF_PRIO3_BIT], sr[`RSF_SR_PRIO_MSB:`RSF_SR_PRIO_LSB]};
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer and register next values
  always_comb begin
    next_state = state;
    next_op = op;
    next_pc_lo = pc_lo;
    next_pc_hi = pc_hi;
    next_sp = sp;
    next_sr = sr;
    next_core_ctrl = core_ctrl;
    next_reset_ctrl = reset_ctrl;
    next_lit_hold = lit_hold;
    next_dst_hold = dst_hold;
    next_wreg_wr = '0;
    next_soft_reset_pulse = 1'b0;
    stack_rd = 1'b0;

    // software register writes; sequencer updates below take priority
    if (reg_wr) begin
      unique case (reg_addr)
        `RSF_ADDR_PC_LO: next_pc_lo = reg_wdata;
        `RSF_ADDR_PC_HI: next_pc_hi = reg_wdata[6:0];
        `RSF_ADDR_SP: next_sp = reg_wdata & 16'hFFFE;
        `RSF_ADDR_SR: next_sr = reg_wdata;
        `RSF_ADDR_CORE_CTRL: next_core_ctrl = reg_wdata;
        `RSF_ADDR_RESET_CTRL: next_reset_ctrl = reg_wdata;
        default: next_sr = sr;
      endcase
    end

    unique case (state)
      rsf_pkg::RSF_IDLE: begin
        if (take && is_soft_reset) begin
          next_pc_lo = `RSF_RST_PC_LO;
          next_pc_hi = `RSF_RST_PC_HI;
          next_sp = `RSF_RST_SP;
          next_sr = `RSF_RST_SR;
          next_core_ctrl = `RSF_RST_CORE_CTRL;
          next_lit_hold = 16'h0000;
          next_dst_hold = 4'h0;
          next_soft_reset_pulse = 1'b1;
          next_reset_ctrl = `RSF_RST_RESET_CTRL;
          next_reset_ctrl[`RSF_SOFT_RESET_FLAG_BIT] = 1'b1;
        end else if (take && (is_ret_int || is_ret_sub || is_ret_lit)) begin
          stack_rd = 1'b1;
          next_sp = stack_addr;
          next_state = rsf_pkg::RSF_POP_LO;
          if (is_ret_int) begin
            next_op = rsf_pkg::RSF_RET_INT;
            next_pc_hi = stack_rdata[`RSF_TOP_PCHI_MSB:`RSF_TOP_PCHI_LSB];
            // restore status byte from the upper half of the word
            next_sr = {sr[15:8], stack_rdata[`RSF_TOP_SR_MSB:`RSF_TOP_SR_LSB]};
            next_core_ctrl[`RSF_PRIO3_BIT] = stack_rdata[`RSF_TOP_PRIO3_BIT];
          end else begin
            next_pc_hi = stack_rdata[6:0];
            next_op = is_ret_lit ? rsf_pkg::RSF_RET_LIT : rsf_pkg::RSF_RET_SUB;
          end
          if (is_ret_lit) begin
            next_lit_hold = lit_merged;
            next_dst_hold = lit_fields.dst;
          end
        end
      end
      rsf_pkg::RSF_POP_LO: begin
        stack_rd = 1'b1;
        next_sp = stack_addr;
        next_pc_lo = stack_rdata;
        if (op == rsf_pkg::RSF_RET_LIT) begin
          next_wreg_wr.en = 1'b1;
          next_wreg_wr.idx = dst_hold;
          next_wreg_wr.data = lit_hold;
        end
        if (exception_pending) begin
          next_state = rsf_pkg::RSF_IDLE;
          next_op = rsf_pkg::RSF_NONE;
        end else begin
          next_state = rsf_pkg::RSF_FLUSH;
        end
      end
      rsf_pkg::RSF_FLUSH: begin
        // refill cycle after the jump
        next_state = rsf_pkg::RSF_IDLE;
        next_op = rsf_pkg::RSF_NONE;
      end
      default: begin
        next_state = rsf_pkg::RSF_IDLE;
        next_op = rsf_pkg::RSF_NONE;
      end
    endcase
  end

  // register read mux, data one cycle after the strobe
  always_comb begin
    next_reg_rdata = 16'h0000;
    if (reg_rd) begin
      unique case (reg_addr)
        `RSF_ADDR_PC_LO: next_reg_rdata = pc_lo;
        `RSF_ADDR_PC_HI: next_reg_rdata = {9'h000, pc_hi};
        `RSF_ADDR_SP: next_reg_rdata = sp;
        `RSF_ADDR_SR: next_reg_rdata = sr;
        `RSF_ADDR_CORE_CTRL: next_reg_rdata = core_ctrl;
        `RSF_ADDR_RESET_CTRL: next_reg_rdata = reset_ctrl;
        default: next_reg_rdata = 16'h0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= rsf_pkg::RSF_IDLE;
      op <= rsf_pkg::RSF_NONE;
      pc_lo <= `RSF_RST_PC_LO;
      pc_hi <= `RSF_RST_PC_HI;
      sp <= `RSF_RST_SP;
      sr <= `RSF_RST_SR;
      core_ctrl <= `RSF_RST_CORE_CTRL;
      reset_ctrl <= `RSF_RST_RESET_CTRL;
      lit_hold <= 16'h0000;
      dst_hold <= 4'h0;
      wreg_wr <= '0;
      soft_reset_pulse <= 1'b0;
      reg_rdata <= 16'h0000;
    end else begin
      state <= next_state;
      op <= next_op;
      pc_lo <= next_pc_lo;
      pc_hi <= next_pc_hi;
      sp <= next_sp;
      sr <= next_sr;
      core_ctrl <= next_core_ctrl;
      reset_ctrl <= next_reset_ctrl;
      lit_hold <= next_lit_hold;
      dst_hold <= next_dst_hold;
      wreg_wr <= next_wreg_wr;
      soft_reset_pulse <= next_soft_reset_pulse;
      reg_rdata <= next_reg_rdata;
    end
  end

endmodule

// ===== tb/rsf_flow_checker.sv
/*
  Checker for the return and software-reset flow: pops, program counter,
  priority level, literal writes and cycle counts.
  Assumes it is bound onto rsf_flow and sees only its ports.
*/
`timescale 1ns/1ps
`include "rsf_consts.svh"
module rsf_flow_checker (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic instr_valid,
  input wire logic [23:0] instr_word,
  input wire logic exception_pending,
  input wire logic instr_ready,
  input wire logic flow_done,
  input wire logic soft_reset_pulse,
  input wire logic [15:0] stack_addr,
  input wire logic stack_rd,
  input wire logic [15:0] stack_rdata,
  input wire rsf_pkg::rsf_wreg_wr_type wreg_wr,
  input wire logic [22:0] pc,
  input wire logic [3:0] interrupt_priority_level
);
  logic take;
  logic is_sub;
  logic is_int;
  logic is_lit;
  // decode of the offered word
  assign take = instr_valid && instr_ready;
  assign is_sub = instr_word == `RSF_OP_RET_SUB;
  assign is_int = instr_word == `RSF_OP_RET_INT;
  assign is_lit = instr_word[23:15] == `RSF_LITRET_CODE;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  //////////////////////////////////////////////////////////////////////
  chk_soft_reset_pc:
  assert property (take && instr_word == `RSF_OP_SOFT_RESET |=> pc == 23'h000000 && soft_reset_pulse ##1 !soft_reset_pulse)
    else $error("soft reset left pc or pulse wrong");
  chk_done_timing:
  assert property (take && (is_sub || is_int || is_lit) |=>
    if (exception_pending) flow_done else (!flow_done ##1 flow_done))
    else $error("return took the wrong number of cycles");
  chk_ready_after_done:
  assert property (flow_done |=> instr_ready)
    else $error("not ready after a return ended");
  chk_pop_step:
  assert property (take && (is_sub || is_int || is_lit) |=> stack_rd && stack_addr == $past(stack_addr) - `RSF_POP_STEP)
    else $error("second pop not two below the first");
  chk_pc_hi_int:
  assert property (take && is_int |=> pc[22:16] == $past(stack_rdata[6:0]))
    else $error("interrupt return upper pc wrong");
  chk_pc_hi_sub:
  assert property (take && (is_sub || is_lit) |=> pc[22:16] == $past(stack_rdata[6:0]))
    else $error("subroutine return upper pc wrong");
  chk_prio_restore:
  assert property (take && is_int |=> interrupt_priority_level == {$past(stack_rdata[7]), $past(stack_rdata[15:13])})
    else $error("priority level not restored");
  chk_pc_lo_pop:
  assert property (stack_rd && !instr_ready |=> pc[15:0] == $past(stack_rdata))
    else $error("lower pc not taken from second pop");
  chk_lit_word:
  assert property (take && is_lit && !instr_word[14] |-> ##2 wreg_wr.en && wreg_wr.idx == $past(instr_word[3:0], 2)
    && wreg_wr.data == {6'h00, $past(instr_word[13:4], 2)})
    else $error("word literal write wrong");
endmodule
bind rsf_flow rsf_flow_checker chk_i (.core_clk(core_clk), .arst_n(arst_n), .instr_valid(instr_valid),
  .instr_word(instr_word), .exception_pending(exception_pending), .instr_ready(instr_ready),
  .flow_done(flow_done), .soft_reset_pulse(soft_reset_pulse), .stack_addr(stack_addr),
  .stack_rd(stack_rd), .stack_rdata(stack_rdata), .wreg_wr(wreg_wr), .pc(pc),
  .interrupt_priority_level(interrupt_priority_level));

// ===== tb/rsf_stack_mem.sv
/*
  Stack memory model: word array read in the same cycle as the pop.
  Assumes the bench loads words through mem before a return.
*/
`timescale 1ns/1ps
module rsf_stack_mem (
  input wire logic core_clk,
  input wire logic [15:0] stack_addr,
  input wire logic stack_rd,
  output logic [15:0] stack_rdata
);
  logic [15:0] mem [0:32767];
  logic [15:0] last = 16'h0000;
  // keep the last word so an idle bus shows its inverse
  always @(posedge core_clk) begin
    if (stack_rd) begin
      last <= stack_rdata;
    end
  end
  // same-cycle read; never a stale copy when idle
  assign stack_rdata = stack_rd ? mem[stack_addr[15:1]] : ~last;
endmodule

// ===== tb/return_and_soft_reset_flow_tb.sv
/*
  Bench for rsf_flow: register port, returns and software reset.
  Assumes rsf_stack_mem as stack and a bench-held working register.
*/
`timescale 1ns/1ps
`include "rsf_consts.svh"
module return_and_soft_reset_flow_tb;
  logic core_clk, arst_n, instr_valid, exception_pending, reg_wr, reg_rd;
  logic instr_ready, flow_done, soft_reset_pulse, stack_rd;
  logic [23:0] instr_word;
  logic [15:0] wreg_old, reg_wdata, stack_addr, stack_rdata, reg_rdata, w_data;
  logic [7:0] reg_addr;
  logic [3:0] wreg_sel, interrupt_priority_level, w_idx;
  logic [22:0] pc;
  rsf_pkg::rsf_wreg_wr_type wreg_wr;
  int err_count, checks_done, cycles, pulses;
  rsf_flow DUT (.core_clk(core_clk), .arst_n(arst_n), .instr_valid(instr_valid), .instr_word(instr_word),
    .exception_pending(exception_pending), .instr_ready(instr_ready), .flow_done(flow_done),
    .soft_reset_pulse(soft_reset_pulse), .stack_addr(stack_addr), .stack_rd(stack_rd),
    .stack_rdata(stack_rdata), .wreg_sel(wreg_sel), .wreg_old(wreg_old), .wreg_wr(wreg_wr), .pc(pc),
    .interrupt_priority_level(interrupt_priority_level), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
  rsf_stack_mem stk (.core_clk(core_clk), .stack_addr(stack_addr), .stack_rd(stack_rd),
    .stack_rdata(stack_rdata));
  //////////////////////////////////////////////////////////////////////
  // clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // capture writes and pulses; cut a hang short
  always @(posedge core_clk) begin
    cycles++;
    if (wreg_wr.en === 1'b1) begin
      w_data <= wreg_wr.data;
      w_idx <= wreg_wr.idx;
    end
    if (soft_reset_pulse === 1'b1) begin
      pulses++;
    end
    if (cycles == 3000) begin
      err_count++;
      final_report();
    end
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [22:0] exp, input logic [22:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdchk(input string what, input logic [7:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(what, 23'(exp), 23'(reg_rdata));
  endtask
  task automatic ld(input logic [15:0] a, input logic [15:0] d);
    stk.mem[a[15:1]] = d;
  endtask
  // offer one word, count cycles to flow_done (8 means none)
  task automatic run(input logic [23:0] w, input logic exc, input int exp_n);
    int n;
    n = 0;
    @(posedge core_clk);
    instr_word <= w;
    instr_valid <= 1'b1;
    exception_pending <= exc;
    @(posedge core_clk);
    instr_valid <= 1'b0;
    #1;
    while (flow_done !== 1'b1 && n < 8) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    @(posedge core_clk);
    exception_pending <= 1'b0;
    @(posedge core_clk);
    #1;
    chk("cycles", 23'(exp_n), 23'(n));
  endtask
  //////////////////////////////////////////////////////////////////////
  task automatic t_lit_byte;
    wr(`RSF_ADDR_SP, 16'h1988);
    ld(16'h1986, 16'h0001);
    ld(16'h1984, 16'h7006);
    wreg_old <= 16'h9846;
    run({9'h00A, 1'b1, 10'h0FF, 4'h0}, 1'b0, 1);
    chk("wdata", 23'h0098FF, 23'(w_data));
    chk("widx", 23'h000000, 23'(w_idx));
    chk("pc", 23'h017006, pc);
    rdchk("sp", `RSF_ADDR_SP, 16'h1984);
    $display("test lit_byte done");
  endtask
  task automatic t_lit_word_exc;
    wr(`RSF_ADDR_SP, 16'h1200);
    ld(16'h11FE, 16'h0001);
    ld(16'h11FC, 16'h7008);
    wreg_old <= 16'hABCD;
    run({9'h00A, 1'b0, 10'h3FF, 4'h2}, 1'b1, 0);
    chk("wdata", 23'h0003FF, 23'(w_data));
    chk("widx", 23'h000002, 23'(w_idx));
    chk("wsel", 23'h000002, 23'(wreg_sel));
    chk("pc", 23'h017008, pc);
    rdchk("sp", `RSF_ADDR_SP, 16'h11FC);
    $display("test lit_word_exc done");
  endtask
  task automatic t_ret_int;
    wr(`RSF_ADDR_SP, 16'h0834);
    ld(16'h0832, 16'hA581);
    ld(16'h0830, 16'h0230);
    // flag cleared first: no exception pending at the return
    run(`RSF_OP_RET_INT, 1'b0, 1);
    chk("pc", 23'h010230, pc);
    chk("prio_level", 23'h00000D, 23'(interrupt_priority_level));
    rdchk("sr", `RSF_ADDR_SR, 16'h00A5);
    rdchk("core_ctrl", `RSF_ADDR_CORE_CTRL, 16'h0028);
    rdchk("sp", `RSF_ADDR_SP, 16'h0830);
    $display("test ret_int done");
  endtask
  task automatic t_ret_sub;
    wr(`RSF_ADDR_SP, 16'h1248);
    ld(16'h1246, 16'h80D5);
    ld(16'h1244, 16'h0004);
    run(`RSF_OP_RET_SUB, 1'b0, 1);
    chk("pc", 23'h550004, pc);
    rdchk("sp", `RSF_ADDR_SP, 16'h1244);
    $display("test ret_sub done");
  endtask
  task automatic t_soft_reset;
    wr(`RSF_ADDR_SR, 16'h00FF);
    wr(`RSF_ADDR_SP, 16'h0500);
    run(`RSF_OP_SOFT_RESET, 1'b0, 8);
    chk("pulses", 23'h000001, 23'(pulses));
    chk("pc", 23'h000000, pc);
    rdchk("sp", `RSF_ADDR_SP, 16'h0000);
    rdchk("sr", `RSF_ADDR_SR, 16'h0000);
    rdchk("core_ctrl", `RSF_ADDR_CORE_CTRL, `RSF_RST_CORE_CTRL);
    rdchk("reset_ctrl", `RSF_ADDR_RESET_CTRL, 16'h0040);
    $display("test soft_reset done");
  endtask
  // reset, then the scenarios in turn
  initial begin
    arst_n = 1'b0;
    instr_valid = 1'b0;
    instr_word = 24'h000000;
    exception_pending = 1'b0;
    wreg_old = 16'h0000;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (16) @(posedge core_clk);
    arst_n <= 1'b1;
    rdchk("core_ctrl", `RSF_ADDR_CORE_CTRL, `RSF_RST_CORE_CTRL);
    rdchk("reset_ctrl", `RSF_ADDR_RESET_CTRL, 16'h0000);
    rdchk("unmapped", 8'h40, 16'h0000);
    t_lit_byte();
    t_lit_word_exc();
    t_ret_int();
    t_ret_sub();
    t_soft_reset();
    final_report();
  end
endmodule
